// ### rtl/udtep_pkg.sv
package udtep_pkg;
    // ----------------------------------------
    // Bus and register map
    // ----------------------------------------
    localparam int          AW             = 12;
    localparam logic [11:0] OFF_RX_START   = 12'h000;
    localparam logic [11:0] OFF_RX_STOP    = 12'h004;
    localparam logic [11:0] OFF_TX_START   = 12'h008;
    localparam logic [11:0] OFF_TX_STOP    = 12'h00c;
    localparam logic [11:0] OFF_RX_DRAIN   = 12'h02c;
    localparam logic [11:0] OFF_LINKS      = 12'h200;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h300;
    localparam logic [11:0] OFF_IRQ_SET    = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR    = 12'h308;
    localparam logic [11:0] OFF_FAULT      = 12'h480;
    localparam logic [11:0] OFF_ENABLE     = 12'h500;
    localparam logic [11:0] OFF_PS_FOUT    = 12'h508;
    localparam logic [11:0] OFF_PS_SOUT    = 12'h50c;
    localparam logic [11:0] OFF_PS_FIN     = 12'h510;
    localparam logic [11:0] OFF_PS_SIN     = 12'h514;
    localparam logic [11:0] OFF_BAUD       = 12'h524;
    localparam logic [11:0] OFF_RX_PTR     = 12'h534;
    localparam logic [11:0] OFF_RX_LIM     = 12'h538;
    localparam logic [11:0] OFF_RX_AMT     = 12'h53c;
    localparam logic [11:0] OFF_TX_PTR     = 12'h544;
    localparam logic [11:0] OFF_TX_LIM     = 12'h548;
    localparam logic [11:0] OFF_TX_AMT     = 12'h54c;
    localparam logic [11:0] OFF_CFG        = 12'h56c;

    // ----------------------------------------
    // Events: index, offset, mask bit
    // ----------------------------------------
    localparam int EV_N = 11;
    localparam int EV_CTS = 0;
    localparam int EV_PEER_NOT_READY_EVENT = 1;
    localparam int EV_RXB = 2;
    localparam int EV_RXEND = 3;
    localparam int EV_TXB = 4;
    localparam int EV_TXEND = 5;
    localparam int EV_ERR = 6;
    localparam int EV_RECEIVER_TIMEOUT_EVENT = 7;
    localparam int EV_RXST = 8;
    localparam int EV_TXST = 9;
    localparam int EV_TXSTP = 10;
    localparam logic [11:0] EV_OFF [EV_N] = '{12'h100, 12'h104, 12'h108, 12'h110, 12'h11c,
                                              12'h120, 12'h124, 12'h144, 12'h14c, 12'h150, 12'h158};
    localparam int EV_BIT [EV_N] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam logic [3:0]  ENABLE_ON      = 4'h8;
    localparam int          PIN_W          = 5;
    localparam int          NPIN           = 32;
    localparam int          PS_DISC_BIT    = 31;
    localparam logic [31:0] PS_RST         = 32'hffff_ffff;
    localparam logic [31:0] BAUD_RST       = 32'h0400_0000;
    localparam int          LIM_W          = 16;
    localparam int          LINK_END_START = 5;
    localparam int          LINK_END_STOP  = 6;
    localparam int          CFG_W          = 5;
    localparam int          CFG_HWFC       = 0;
    localparam int          FAULT_W        = 4;
    localparam logic [LIM_W-1:0] CNT_ONE   = 16'h0001;

    typedef enum logic [3:0] {
        TXS_IDLE  = 4'b0001,
        TXS_READY = 4'b0010,
        TXS_BUSY  = 4'b0100,
        TXS_HALT  = 4'b1000
    } udtep_tx_t;

    typedef enum logic [4:0] {
        RXS_IDLE  = 5'b00001,
        RXS_RUN   = 5'b00010,
        RXS_FULL  = 5'b00100,
        RXS_DRAIN = 5'b01000,
        RXS_TOUT  = 5'b10000
    } udtep_rx_t;
endpackage

// ### rtl/udtep_core.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
// Function
// RULE_01 - Software stops unit, then disables it
// RULE_02 - Await stopped/timeout event before disabling
// RULE_03 - Four pin selects route serial signals
// RULE_04 - Flow signals are active low
// RULE_05 - Pin selects apply only while enabled
// RULE_06 - Pin selects written only while disabled
// RULE_07 - Idle pins: inputs, outputs held high
// RULE_08 - One driver per physical pin
// RULE_09 - Task writes start/stop receiver, transmitter
// RULE_10 - Drain task empties receive FIFO
// RULE_11 - Flow input asserted sets ready flag
// RULE_12 - Flow input released sets not-ready flag
// RULE_13 - Flag each received byte
// RULE_14 - Flag receive buffer full
// RULE_15 - Flag each sent byte, last byte
// RULE_16 - Error flag plus one-clear cause bits
// RULE_17 - Flags for started, timeout, stopped
// RULE_18 - Receive and transmit byte limits
// RULE_19 - Read-back moved byte counts
// RULE_20 - Parity and flow control in config
// RULE_21 - Transmit until limit, then end event
// RULE_22 - Receive end precedes timeout on stop
// RULE_23 - Flags clear on zero write only
// RULE_24 - Interrupt from enabled flags, set/clear aliases
module udtep_core (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // APB slave
    input  wire logic [udtep_pkg::AW-1:0]      paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    // Physical pins
    input  wire logic [udtep_pkg::NPIN-1:0]    pin_in,
    output logic [udtep_pkg::NPIN-1:0]         pin_out,
    output logic [udtep_pkg::NPIN-1:0]         pin_oe,
    // Serial engine side
    input  wire logic                          serial_out_bit,
    output logic                               serial_in_bit,
    output logic                               tx_byte_req,
    input  wire logic                          tx_byte_done,
    input  wire logic                          rx_byte_done,
    input  wire logic [udtep_pkg::FAULT_W-1:0] rx_fault,
    output logic                               rx_store,
    output logic                               rx_fifo_drain_task,
    output logic [31:0]                        bit_rate,
    output logic [udtep_pkg::CFG_W-1:0]        frame_cfg,
    output logic [31:0]                        rx_ptr,
    output logic [31:0]                        tx_ptr,
    output logic [udtep_pkg::LIM_W-1:0]        rx_index,
    output logic [udtep_pkg::LIM_W-1:0]        tx_index,
    output logic                               unit_on,
    // Interrupt
    output logic                               irq
);
    import udtep_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0]       enable_q;
    logic [31:0]      ps_fout_q;
    logic [31:0]      ps_sout_q;
    logic [31:0]      ps_fin_q;
    logic [31:0]      ps_sin_q;
    logic [31:0]      baud_q;
    logic [31:0]      rx_ptr_q;
    logic [31:0]      tx_ptr_q;
    logic [LIM_W-1:0] rx_lim_q;
    logic [LIM_W-1:0] tx_lim_q;
    logic [LIM_W-1:0] rx_cnt_q;
    logic [LIM_W-1:0] tx_cnt_q;
    logic [LIM_W-1:0] tx_end_q;
    logic [CFG_W-1:0] cfg_q;
    logic [1:0]       links_q;
    logic [31:0]      mask_q;
    logic [FAULT_W-1:0] fault_q;
    logic [EV_N-1:0]  flag_q;
    logic [EV_N-1:0]  ev_set;
    logic [31:0]      flag_vec;
    logic             cts_prev_q;
    logic             tx_stop_pend_q;
    logic             drain_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;
    udtep_tx_t        tx_q;
    udtep_rx_t        rx_q;

    logic wr;
    logic setup;
    logic hwfc;
    logic cts_n;
    logic rts_n;
    logic t_rx_start;
    logic t_rx_stop;
    logic t_tx_start;
    logic t_tx_stop;
    logic t_drain;
    logic rx_last;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign unit_on = (enable_q == ENABLE_ON);
    assign hwfc    = cfg_q[CFG_HWFC];

    assign t_rx_start = wr & (paddr == OFF_RX_START) & pwdata[0] & unit_on;  // RULE_09
    assign t_rx_stop  = wr & (paddr == OFF_RX_STOP) & pwdata[0] & unit_on;   // RULE_09
    assign t_tx_start = wr & (paddr == OFF_TX_START) & pwdata[0] & unit_on;  // RULE_09
    assign t_tx_stop  = wr & (paddr == OFF_TX_STOP) & pwdata[0] & unit_on;   // RULE_09
    assign t_drain    = wr & (paddr == OFF_RX_DRAIN) & pwdata[0] & unit_on;  // RULE_10

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    // Disconnected flow input reads as asserted
    assign cts_n = (unit_on & ~ps_fin_q[PS_DISC_BIT]) ?
                   pin_in[ps_fin_q[PIN_W-1:0]] : 1'b0;  // RULE_05
    assign serial_in_bit = (unit_on & ~ps_sin_q[PS_DISC_BIT]) ?
                           pin_in[ps_sin_q[PIN_W-1:0]] : 1'b1;  // RULE_03
    assign rts_n = ~(hwfc & (rx_q == RXS_RUN));  // RULE_04

    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_pin
            logic sel_t;
            logic sel_r;
            assign sel_t = unit_on & ~ps_sout_q[PS_DISC_BIT] &
                           (ps_sout_q[PIN_W-1:0] == PIN_W'(p));  // RULE_03
            assign sel_r = unit_on & ~ps_fout_q[PS_DISC_BIT] &
                           (ps_fout_q[PIN_W-1:0] == PIN_W'(p));  // RULE_05
            assign pin_oe[p]  = sel_t | sel_r;
            assign pin_out[p] = sel_t ? serial_out_bit : (sel_r ? rts_n : 1'b1);
        end
    endgenerate

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable_q <= 4'h0;
            baud_q   <= BAUD_RST;
            cfg_q    <= '0;
            links_q  <= 2'b00;
            rx_ptr_q <= 32'h0000_0000;
            tx_ptr_q <= 32'h0000_0000;
            rx_lim_q <= '0;
            tx_lim_q <= '0;
        end else if (wr) begin
            unique case (paddr)
                OFF_ENABLE: enable_q <= pwdata[3:0];
                OFF_BAUD:   baud_q   <= pwdata;
                OFF_CFG:    cfg_q    <= pwdata[CFG_W-1:0];  // RULE_20
                OFF_LINKS:  links_q  <= {pwdata[LINK_END_STOP], pwdata[LINK_END_START]};
                OFF_RX_PTR: rx_ptr_q <= pwdata;
                OFF_TX_PTR: tx_ptr_q <= pwdata;
                OFF_RX_LIM: rx_lim_q <= pwdata[LIM_W-1:0];  // RULE_18
                OFF_TX_LIM: tx_lim_q <= pwdata[LIM_W-1:0];  // RULE_18
                default: ;
            endcase
        end
    end

    // Pin selects frozen while the unit runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ps_fout_q <= PS_RST;
            ps_sout_q <= PS_RST;
            ps_fin_q  <= PS_RST;
            ps_sin_q  <= PS_RST;
        end else if (wr && !unit_on) begin  // RULE_06
            unique case (paddr)
                OFF_PS_FOUT: ps_fout_q <= pwdata;
                OFF_PS_SOUT: ps_sout_q <= pwdata;
                OFF_PS_FIN:  ps_fin_q  <= pwdata;
                OFF_PS_SIN:  ps_sin_q  <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_q <= 32'h0000_0000;
        end else if (wr) begin
            unique case (paddr)
                OFF_IRQ_MASK: mask_q <= pwdata;
                OFF_IRQ_SET:  mask_q <= mask_q | pwdata;   // RULE_24
                OFF_IRQ_CLR:  mask_q <= mask_q & ~pwdata;  // RULE_24
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    assign tx_byte_req = (tx_q == TXS_READY) & ~tx_stop_pend_q & ~t_tx_stop &
                         (tx_cnt_q != tx_end_q) & (~hwfc | ~cts_n);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_q           <= TXS_IDLE;
            tx_cnt_q       <= '0;
            tx_end_q       <= '0;
            tx_stop_pend_q <= 1'b0;
        end else begin
            unique case (tx_q)
                TXS_IDLE: begin
                    tx_stop_pend_q <= 1'b0;
                    if (t_tx_start) begin
                        tx_q     <= TXS_READY;
                        tx_cnt_q <= '0;
                        tx_end_q <= tx_lim_q;
                    end
                end
                TXS_READY: begin
                    if (t_tx_stop || tx_stop_pend_q) begin
                        tx_q <= TXS_HALT;
                    end else if (tx_cnt_q == tx_end_q) begin
                        tx_q <= TXS_IDLE;  // RULE_21
                    end else if (tx_byte_req) begin
                        tx_q <= TXS_BUSY;
                    end
                end
                TXS_BUSY: begin
                    if (t_tx_stop) begin
                        tx_stop_pend_q <= 1'b1;
                    end
                    if (tx_byte_done) begin
                        tx_cnt_q <= tx_cnt_q + CNT_ONE;  // RULE_19
                        tx_q     <= TXS_READY;
                    end
                end
                TXS_HALT: begin
                    tx_q           <= TXS_IDLE;
                    tx_stop_pend_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    assign rx_store = (rx_q == RXS_RUN);
    assign rx_last  = rx_byte_done & ((rx_cnt_q + CNT_ONE) == rx_lim_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_q     <= RXS_IDLE;
            rx_cnt_q <= '0;
        end else begin
            unique case (rx_q)
                RXS_IDLE: begin
                    if (t_rx_start) begin
                        rx_q     <= RXS_RUN;
                        rx_cnt_q <= '0;
                    end else if (t_drain) begin
                        rx_cnt_q <= '0;
                    end
                end
                RXS_RUN: begin
                    if (rx_last) begin
                        rx_cnt_q <= links_q[0] ? '0 : rx_cnt_q + CNT_ONE;  // RULE_19
                        rx_q     <= links_q[0] ? RXS_RUN :
                                    ((links_q[1] || t_rx_stop) ? RXS_TOUT : RXS_FULL);
                    end else begin
                        if (rx_byte_done) begin
                            rx_cnt_q <= rx_cnt_q + CNT_ONE;  // RULE_19
                        end
                        if (t_rx_stop) begin
                            rx_q <= RXS_DRAIN;
                        end
                    end
                end
                RXS_FULL: begin
                    if (t_rx_stop) begin
                        rx_q <= RXS_TOUT;
                    end else if (t_rx_start) begin
                        rx_q     <= RXS_RUN;
                        rx_cnt_q <= '0;
                    end
                end
                RXS_DRAIN: rx_q <= RXS_TOUT;  // RULE_22
                RXS_TOUT:  rx_q <= RXS_IDLE;
            endcase
        end
    end

    // Drain completes with a buffer-end event one cycle later
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drain_q <= 1'b0;
        end else begin
            drain_q <= t_drain & (rx_q == RXS_IDLE);  // RULE_10
        end
    end
    assign rx_fifo_drain_task = drain_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cts_prev_q <= 1'b0;
        end else begin
            cts_prev_q <= cts_n;
        end
    end

    // ----------------------------------------
    // Event sources
    // ----------------------------------------
    always_comb begin
        ev_set            = '0;
        ev_set[EV_CTS]    = cts_prev_q & ~cts_n;   // RULE_11
        ev_set[EV_PEER_NOT_READY_EVENT]   = ~cts_prev_q & cts_n;   // RULE_12
        ev_set[EV_RXB]    = rx_byte_done & (rx_q != RXS_IDLE);  // RULE_13
        ev_set[EV_RXEND]  = ((rx_q == RXS_RUN) & rx_last) | (rx_q == RXS_DRAIN) | drain_q;  // RULE_14
        ev_set[EV_TXB]    = (tx_q == TXS_BUSY) & tx_byte_done;  // RULE_15
        ev_set[EV_TXEND]  = (tx_q == TXS_HALT) |
                            ((tx_q == TXS_READY) & ~t_tx_stop & ~tx_stop_pend_q &
                             (tx_cnt_q == tx_end_q));  // RULE_21
        ev_set[EV_ERR]    = |rx_fault;  // RULE_16
        ev_set[EV_RECEIVER_TIMEOUT_EVENT]   = (rx_q == RXS_TOUT);  // RULE_22
        ev_set[EV_RXST]   = ((rx_q == RXS_IDLE) | (rx_q == RXS_FULL)) & t_rx_start |
                            (rx_q == RXS_RUN) & rx_last & links_q[0];  // RULE_17
        ev_set[EV_TXST]   = (tx_q == TXS_IDLE) & t_tx_start;  // RULE_17
        ev_set[EV_TXSTP]  = (tx_q == TXS_HALT) | ((tx_q == TXS_IDLE) & t_tx_stop);  // RULE_17
    end

    // Set beats a same-cycle zero write
    genvar e;
    generate
        for (e = 0; e < EV_N; e++) begin : g_ev
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    flag_q[e] <= 1'b0;
                end else if (ev_set[e]) begin
                    flag_q[e] <= 1'b1;
                end else if (wr && paddr == EV_OFF[e] && !pwdata[0]) begin
                    flag_q[e] <= 1'b0;  // RULE_23
                end
            end
        end
    endgenerate

    always_comb begin
        flag_vec = 32'h0000_0000;
        for (int i = 0; i < EV_N; i++) begin
            flag_vec[EV_BIT[i]] = flag_q[i];
        end
    end
    assign irq = |(flag_vec & mask_q);  // RULE_24

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_q <= '0;
        end else begin
            // New causes survive a same-cycle clear
            fault_q <= (wr && paddr == OFF_FAULT) ?
                       ((fault_q & ~pwdata[FAULT_W-1:0]) | rx_fault) :
                       (fault_q | rx_fault);  // RULE_16
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            unique case (paddr)
                OFF_RX_START, OFF_RX_STOP, OFF_TX_START, OFF_TX_STOP, OFF_RX_DRAIN: ;
                OFF_LINKS:   prdata_q <= {25'h0, links_q[1], links_q[0], 5'h00};
                OFF_IRQ_MASK, OFF_IRQ_SET, OFF_IRQ_CLR: prdata_q <= mask_q;
                OFF_FAULT:   prdata_q[FAULT_W-1:0] <= fault_q;
                OFF_ENABLE:  prdata_q[3:0] <= enable_q;
                OFF_PS_FOUT: prdata_q <= ps_fout_q;
                OFF_PS_SOUT: prdata_q <= ps_sout_q;
                OFF_PS_FIN:  prdata_q <= ps_fin_q;
                OFF_PS_SIN:  prdata_q <= ps_sin_q;
                OFF_BAUD:    prdata_q <= baud_q;
                OFF_RX_PTR:  prdata_q <= rx_ptr_q;
                OFF_TX_PTR:  prdata_q <= tx_ptr_q;
                OFF_RX_LIM:  prdata_q[LIM_W-1:0] <= rx_lim_q;
                OFF_TX_LIM:  prdata_q[LIM_W-1:0] <= tx_lim_q;
                OFF_RX_AMT:  prdata_q[LIM_W-1:0] <= rx_cnt_q;  // RULE_19
                OFF_TX_AMT:  prdata_q[LIM_W-1:0] <= tx_cnt_q;  // RULE_19
                OFF_CFG:     prdata_q[CFG_W-1:0] <= cfg_q;
                default: begin
                    pslverr_q <= 1'b1;
                    for (int i = 0; i < EV_N; i++) begin
                        if (paddr == EV_OFF[i]) begin
                            prdata_q[0] <= flag_q[i];
                            pslverr_q   <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Engine-facing outputs
    // ----------------------------------------
    assign bit_rate  = baud_q;
    assign frame_cfg = cfg_q;
    assign rx_ptr    = rx_ptr_q;
    assign tx_ptr    = tx_ptr_q;
    assign rx_index  = rx_cnt_q;
    assign tx_index  = tx_cnt_q;
endmodule

// ### bench/udtep_properties.sv
`timescale 1ns/1ps
module udtep_props (
    // Clock, reset and bus
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    // Pins, engine and interrupt
    input wire logic [31:0] pin_oe,
    input wire logic        tx_byte_req,
    input wire logic        rx_store,
    input wire logic        rx_fifo_drain_task,
    input wire logic        unit_on,
    input wire logic        irq
);
    import udtep_pkg::*;
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_enable_decode: assert property (
        wr && paddr == OFF_ENABLE |=> unit_on == ($past(pwdata[3:0]) == ENABLE_ON)) else $error("enable decode");
    a_pins_released: assert property (
        !unit_on |-> pin_oe == '0) else $error("pin driven while off");
    a_irq_mask_off: assert property (
        wr && paddr == OFF_IRQ_MASK && pwdata == '0 |=> !irq) else $error("irq with empty mask");
    a_irq_set_keeps: assert property (
        irq && wr && paddr == OFF_IRQ_SET |=> irq) else $error("set alias dropped irq");
    a_tx_req_pulse: assert property (
        tx_byte_req |=> !tx_byte_req) else $error("byte request held");
    a_tx_req_enabled: assert property (
        tx_byte_req |-> unit_on) else $error("byte request while off");
    a_rx_start_store: assert property (
        wr && paddr == OFF_RX_START && pwdata[0] && unit_on |-> ##[1:2] rx_store) else $error("receiver idle");
    a_drain_pulse: assert property (
        wr && paddr == OFF_RX_DRAIN && pwdata[0] && unit_on && !rx_store |-> ##[1:2] rx_fifo_drain_task
        ##1 !rx_fifo_drain_task) else $error("drain pulse wrong");
    c_tx_byte: cover property (tx_byte_req);
    c_drain: cover property (rx_fifo_drain_task);
    c_irq: cover property (irq);
endmodule
bind udtep_core udtep_props udtep_props_inst (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pin_oe, .tx_byte_req, .rx_store, .rx_fifo_drain_task, .unit_on, .irq);

// ### bench/udtep_peer.sv
`timescale 1ns/1ps
module udtep_peer #(
    parameter int DLY = 6
) (
    // Handshake and flow
    input  wire logic        sys_clk,
    input  wire logic        cts_lvl,
    input  wire logic        tx_byte_req,
    output logic             tx_byte_done,
    // Line levels
    output logic [31:0]      pin_in
);
    int cnt = 0;
    // Pulled-up idle lines, flow input on pin 3
    assign pin_in = {{28{1'b1}}, cts_lvl, 3'b111};
    assign tx_byte_done = (cnt == 1);
    always_ff @(posedge sys_clk) begin
        if (tx_byte_req) cnt <= DLY;
        else if (cnt != 0) cnt <= cnt - 1;
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import udtep_pkg::*;
    localparam logic [11:0] RA [5] = '{OFF_IRQ_MASK, OFF_PS_FIN, OFF_BAUD, OFF_TX_START, OFF_RX_AMT};
    localparam logic [31:0] RV [5] = '{32'h0, 32'hffff_ffff, 32'h0400_0000, 32'h0, 32'h0};
    localparam int          TXE [3] = '{EV_TXB, EV_TXEND, EV_TXST};
    localparam int          RXE [3] = '{EV_RXB, EV_RXEND, EV_RXST};
    logic        sys_clk, rst_n, psel, penable, pwrite, rx_byte_done, cts_lvl, rerr;
    logic        pready, pslverr, tx_byte_req, tx_byte_done, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pin_in, pin_oe, pin_out, rdat;
    logic [3:0]  rx_fault;
    int          n_mismatch = 0, num_checks = 0;
    udtep_core udtep_core_inst (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
        .pslverr, .pin_in, .pin_out, .pin_oe, .serial_out_bit(1'b1), .serial_in_bit(), .tx_byte_req,
        .tx_byte_done, .rx_byte_done, .rx_fault, .rx_store(), .rx_fifo_drain_task(), .bit_rate(), .frame_cfg(),
        .rx_ptr(), .tx_ptr(), .rx_index(), .tx_index(), .unit_on(), .irq);
    udtep_peer #(.DLY(6)) udtep_peer_inst (.sys_clk, .cts_lvl, .tx_byte_req, .tx_byte_done, .pin_in);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop(input int to);
        n_mismatch += to;
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ----
    // Bus cycle: setup, access until ready
    // ----
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) report_and_stop(1);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xf(1'b0, a, '0);
        ck($sformatf("reg %h", a), e, rdat);
    endtask
    task automatic pw(input logic [11:0] a);
        rdat = '0;
        for (int k = 0; k < 30 && rdat[0] !== 1'b1; k++) xf(1'b0, a, '0);
        ck($sformatf("flag %h", a), 32'h1, rdat);
    endtask
    task automatic pls(input logic [3:0] f);
        @(posedge sys_clk);
        rx_byte_done <= ~|f;
        rx_fault     <= f;
        @(posedge sys_clk);
        rx_byte_done <= 1'b0;
        rx_fault     <= '0;
    endtask
    initial begin
        {psel, penable, pwrite, rx_byte_done, cts_lvl, rst_n} = '0;
        paddr = '0;
        pwdata = '0;
        rx_fault = '0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (RA[k]) rc(RA[k], RV[k]);
        xf(1'b0, 12'h0fc, '0);
        ck("unmapped", 32'h1, {rdat[30:0], rerr});
        xf(1'b1, OFF_PS_FIN, 32'h3);
        xf(1'b1, OFF_PS_SOUT, 32'h5);
        xf(1'b1, OFF_PS_FOUT, 32'h6);
        xf(1'b1, OFF_ENABLE, 32'(ENABLE_ON));
        xf(1'b1, OFF_PS_FIN, 32'h7);
        ck("pin_oe", 32'h60, pin_oe);
        rc(OFF_PS_FIN, 32'h3);
        cts_lvl <= 1'b1;
        pw(EV_OFF[EV_PEER_NOT_READY_EVENT]);
        cts_lvl <= 1'b0;
        pw(EV_OFF[EV_CTS]);
        xf(1'b1, EV_OFF[EV_CTS], '0);
        rc(EV_OFF[EV_CTS], '0);
        xf(1'b1, OFF_TX_LIM, 32'h2);
        xf(1'b1, OFF_TX_START, 32'h1);
        foreach (TXE[k]) pw(EV_OFF[TXE[k]]);
        rc(OFF_TX_AMT, 32'h2);
        xf(1'b1, OFF_IRQ_MASK, '0);
        xf(1'b1, OFF_IRQ_SET, 32'h1 << EV_BIT[EV_TXEND]);
        @(negedge sys_clk);
        ck("irq", 32'h1, 32'(irq));
        xf(1'b1, OFF_IRQ_SET, 32'h1);
        xf(1'b1, OFF_IRQ_CLR, 32'h1 << EV_BIT[EV_TXEND]);
        @(negedge sys_clk);
        ck("irq", 32'h0, 32'(irq));
        rc(OFF_IRQ_MASK, 32'h1);
        xf(1'b1, OFF_TX_STOP, 32'h1);
        pw(EV_OFF[EV_TXSTP]);
        xf(1'b1, OFF_CFG, 32'h1);
        xf(1'b1, OFF_RX_LIM, 32'h2);
        xf(1'b1, OFF_RX_START, 32'h1);
        pls(4'h0);
        ck("rts running", 32'h0, 32'(pin_out[6]));
        pls(4'h0);
        foreach (RXE[k]) pw(EV_OFF[RXE[k]]);
        rc(OFF_RX_AMT, 32'h2);
        ck("rts full", 32'h1, 32'(pin_out[6]));
        xf(1'b1, OFF_RX_STOP, 32'h1);
        pw(EV_OFF[EV_RECEIVER_TIMEOUT_EVENT]);
        pls(4'h2);
        pw(EV_OFF[EV_ERR]);
        rc(OFF_FAULT, 32'h2);
        xf(1'b1, OFF_FAULT, 32'h2);
        rc(OFF_FAULT, '0);
        xf(1'b1, EV_OFF[EV_RXEND], '0);
        xf(1'b1, OFF_RX_DRAIN, 32'h1);
        pw(EV_OFF[EV_RXEND]);
        xf(1'b1, OFF_ENABLE, '0);
        @(negedge sys_clk);
        ck("pin_oe off", 32'h0, pin_oe);
        report_and_stop(0);
    end
endmodule
